/* obd_pkg.sv */
/*
  Shared constants for the option byte configuration decoder: bus offsets,
  option byte field positions, blank and erased values, decoded mode codes.
  Assumes a 32-bit Avalon-MM slave port with byte addresses.
*/
package obd_pkg;

  // Bus geometry
  localparam int OBD_AW = 10;
  localparam int OBD_DW = 32;

  // Register byte offsets
  localparam logic [OBD_AW-1:0] OFS_OPT0 = 10'h000;
  localparam logic [OBD_AW-1:0] OFS_OPT1 = 10'h004;
  localparam logic [OBD_AW-1:0] OFS_STAT = 10'h008;
  localparam logic [OBD_AW-1:0] OFS_PMEM = 10'h100;

  // Status register bit positions
  localparam int STAT_PROG_BIT = 0;
  localparam int STAT_ROM_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_PROT_BIT = 3;

  // Option byte 0 fields
  localparam int OPT0_PROT_BIT = 0;
  localparam int OPT0_MAP_BIT = 1;

  // Option byte 1 fields
  localparam int OPT1_WSW_BIT = 0;
  localparam int OPT1_WHR_BIT = 1;
  localparam int OPT1_LVD_LSB = 2;
  localparam int OPT1_OSC_LSB = 4;
  localparam int OPT1_CFO_BIT = 7;

  // Array contents and hardwired defaults
  localparam logic [7:0] BLANK_BYTE = 8'hFF;
  localparam logic [7:0] ERASED_BYTE = 8'h00;
  localparam logic [7:0] ROM_OPT0_DEF = 8'hFE;
  localparam logic [7:0] ROM_OPT1_DEF = 8'hEF;
  localparam int PMEM_DEPTH_DEF = 16;

  // Main oscillator kinds
  typedef enum logic [2:0] {
    OSC_HIGH_SPEED_RESONATOR = 3'h0,
    OSC_MEDIUM_SPEED_RESONATOR = 3'h1,
    OSC_MEDIUM_POWER_RESONATOR = 3'h2,
    OSC_LOW_POWER_RESONATOR = 3'h3,
    OSC_EXT_RC = 3'h4,
    OSC_INT_RC = 3'h6,
    OSC_EXT_CLOCK = 3'h7
  } obd_osc_t;

  // Low-voltage detector settings
  typedef enum logic [1:0] {
    LVD_LOWEST = 2'h0,
    LVD_MEDIUM = 2'h1,
    LVD_HIGHEST = 2'h2,
    LVD_OFF = 2'h3
  } obd_lvd_t;

  // Bus slave states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_RESP = 2'h1,
    BUS_ERASE = 2'h2
  } obd_bus_t;

endpackage : obd_pkg

/* obd_nvstore.sv */
/*
  Non-volatile store: two option bytes and a small program memory array,
  with a sequenced full erase. Factory-coded builds hold hardwired values.
  Assumes single-cycle write strobes from the bus slave.
*/
`timescale 1ns/100ps
module obd_nvstore #(
  parameter int PMEM_DEPTH = obd_pkg::PMEM_DEPTH_DEF,
  parameter bit FACTORY = 1'b0,
  parameter logic [7:0] ROM_OPT0 = obd_pkg::ROM_OPT0_DEF,
  parameter logic [7:0] ROM_OPT1 = obd_pkg::ROM_OPT1_DEF
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic nv_blank,
  input wire logic wr_opt0,
  input wire logic wr_opt1,
  input wire logic wr_pmem,
  input wire logic [$clog2(PMEM_DEPTH)-1:0] wr_index,
  input wire logic [7:0] wr_data,
  input wire logic erase_start,
  input wire logic [$clog2(PMEM_DEPTH)-1:0] rd_index,
  output logic [7:0] opt0,
  output logic [7:0] opt1,
  output logic [7:0] pmem_rd,
  output logic erase_busy
);
  import obd_pkg::*;

  localparam int IW = $clog2(PMEM_DEPTH);
  localparam logic [IW-1:0] LAST_IDX = IW'(PMEM_DEPTH - 1);

  logic [7:0] opt0_q, opt0_d, opt1_q, opt1_d;
  logic [7:0] pmem_q [PMEM_DEPTH];
  logic [7:0] pmem_d [PMEM_DEPTH];
  logic busy_q, busy_d;
  logic [IW-1:0] cnt_q, cnt_d;

  // Next contents: blank load, erase walk, then programming writes
  always_comb begin
    opt0_d = opt0_q;
    opt1_d = opt1_q;
    pmem_d = pmem_q;
    busy_d = busy_q;
    cnt_d = cnt_q;
    if (sys_rst) begin
      busy_d = 1'b0;
      cnt_d = '0;
      if (nv_blank) begin
        opt0_d = BLANK_BYTE;
        opt1_d = BLANK_BYTE;
        for (int i = 0; i < PMEM_DEPTH; i++) pmem_d[i] = BLANK_BYTE;
      end
    end else if (busy_q) begin
      pmem_d[cnt_q] = ERASED_BYTE;
      cnt_d = cnt_q + IW'(1);
      if (cnt_q == LAST_IDX) begin
        opt0_d = ERASED_BYTE; // Protection drops on the same edge that clears the last array entry
        opt1_d = ERASED_BYTE;
        busy_d = 1'b0;
        cnt_d = '0;
      end
    end else if (!FACTORY) begin
      if (erase_start) busy_d = 1'b1;
      else if (wr_opt0) opt0_d = wr_data;
      else if (wr_opt1) opt1_d = wr_data;
      else if (wr_pmem) pmem_d[wr_index] = wr_data;
    end
  end

  // Store registers
  always_ff @(posedge sys_clk) begin
    opt0_q <= opt0_d;
    opt1_q <= opt1_d;
    pmem_q <= pmem_d;
    busy_q <= busy_d;
    cnt_q <= cnt_d;
  end

  // Hardwired option values win in factory-coded builds
  assign opt0 = FACTORY ? ROM_OPT0 : opt0_q;
  assign opt1 = FACTORY ? ROM_OPT1 : opt1_q;
  assign pmem_rd = pmem_q[rd_index];
  assign erase_busy = busy_q;

endmodule : obd_nvstore

/* obd_decode.sv */
/*
  Combinational decode of the two option bytes into configuration fields.
  Assumes the caller registers the results.
*/
`timescale 1ns/100ps
module obd_decode (
  input wire logic [7:0] opt0,
  input wire logic [7:0] opt1,
  output logic ext_irq_map_select,
  output logic readout_protect,
  output logic clock_filter_off,
  output logic [2:0] clock_source_select,
  output obd_pkg::obd_osc_t osc_kind,
  output obd_pkg::obd_lvd_t low_voltage_detect_select,
  output logic watchdog_halt_reset,
  output logic watchdog_software_mode
);
  import obd_pkg::*;

  // Plain field extraction
  assign ext_irq_map_select = opt0[OPT0_MAP_BIT];
  assign readout_protect = opt0[OPT0_PROT_BIT];
  assign clock_filter_off = opt1[OPT1_CFO_BIT];
  assign clock_source_select = opt1[OPT1_OSC_LSB +: 3];
  assign low_voltage_detect_select = obd_lvd_t'(opt1[OPT1_LVD_LSB +: 2]);
  assign watchdog_halt_reset = opt1[OPT1_WHR_BIT];
  assign watchdog_software_mode = opt1[OPT1_WSW_BIT];

  // Oscillator kind; both external RC codes collapse to one kind
  always_comb begin
    case (clock_source_select)
      3'h7: osc_kind = OSC_EXT_CLOCK;
      3'h6: osc_kind = OSC_INT_RC;
      3'h5, 3'h4: osc_kind = OSC_EXT_RC;
      3'h3: osc_kind = OSC_LOW_POWER_RESONATOR;
      3'h2: osc_kind = OSC_MEDIUM_POWER_RESONATOR;
      3'h1: osc_kind = OSC_MEDIUM_SPEED_RESONATOR;
      default: osc_kind = OSC_HIGH_SPEED_RESONATOR;
    endcase
  end

endmodule : obd_decode

/* obd_top.sv */
/*
  Option byte configuration decoder top: programming-mode Avalon-MM slave,
  non-volatile option store, configuration sampled at reset, interrupt
  vector mapping and watchdog halt reset request.
  Assumes all inputs synchronous to sys_clk and a synchronous high reset.
*/
// The address map and the Avalon-MM slave port were decided locally.
// Operation
// - Option bytes are reachable only in programming mode, never by the processor.
// - A blank user-programmable part reads all ones until programmed; here program memory reads zero, since the blank protect bit blocks it.
// - Factory-coded parts use hardwired options that programming cannot change.
// - Map bit chooses whether port C lines join vector 0 or vector 1.
// - Protect bit set blocks outside reads of program memory.
// - Clearing protection erases all program memory and option bytes to zero first.
// - Clock filter bit zero enables the filter, one disables it.
// - Three oscillator bits select the main clock source kind.
// - Two detector bits select off or one of three thresholds.
// - Halt reset bit makes halt entry reset while the watchdog runs.
// - Watchdog mode bit zero forces the watchdog on by hardware.
`timescale 1ns/100ps
module obd_top #(
  parameter int PMEM_DEPTH = obd_pkg::PMEM_DEPTH_DEF,
  parameter bit FACTORY = 1'b0,
  parameter logic [7:0] ROM_OPT0 = obd_pkg::ROM_OPT0_DEF,
  parameter logic [7:0] ROM_OPT1 = obd_pkg::ROM_OPT1_DEF
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic nv_blank,
  input wire logic prog_mode,
  input wire logic [obd_pkg::OBD_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [obd_pkg::OBD_DW-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [obd_pkg::OBD_DW-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] port_a_irq,
  input wire logic [7:0] port_b_irq,
  input wire logic [5:0] port_c_irq,
  output logic ext_irq0_req,
  output logic ext_irq1_req,
  input wire logic halt_entry,
  input wire logic watchdog_sw_enable,
  output logic halt_reset_req,
  output logic ext_irq_map_select,
  output logic readout_protect,
  output logic clock_filter_off,
  output logic [2:0] clock_source_select,
  output obd_pkg::obd_osc_t osc_kind,
  output logic low_voltage_detect_enable,
  output obd_pkg::obd_lvd_t low_voltage_detect_select,
  output logic watchdog_halt_reset,
  output logic watchdog_software_mode,
  output logic watchdog_hw_enable
);
  import obd_pkg::*;

  localparam int IW = $clog2(PMEM_DEPTH);

  // True when a word-aligned byte address falls inside the program memory window
  function automatic logic pmem_hit(input logic [OBD_AW-1:0] a);
    pmem_hit = (a >= OFS_PMEM) && (a < OFS_PMEM + OBD_AW'(4 * PMEM_DEPTH))
      && (a[1:0] == 2'h0);
  endfunction : pmem_hit

  // Word index of a program memory byte address
  function automatic logic [IW-1:0] pmem_idx(input logic [OBD_AW-1:0] a);
    logic [OBD_AW-1:0] off;
    off = a - OFS_PMEM;
    pmem_idx = off[IW+1:2];
  endfunction : pmem_idx

  // Store interface
  logic [7:0] opt0, opt1, pmem_rd;
  logic erase_busy;
  logic wr_opt0, wr_opt1, wr_pmem, erase_start;

  // Decoded, not yet sampled
  logic dec_map, dec_prot, dec_cfo, dec_whr, dec_wsw;
  logic [2:0] dec_osc_sel;
  obd_osc_t dec_osc_kind;
  obd_lvd_t dec_lvd;

  // Bus slave state
  obd_bus_t st_q, st_d;
  logic wait_q, wait_d;
  logic [OBD_DW-1:0] rdata_q, rdata_d;

  // Sampled configuration
  logic map_q, map_d, prot_q, prot_d, cfo_q, cfo_d;
  logic whr_q, whr_d, wsw_q, wsw_d, lvd_en_q, lvd_en_d, hw_wdg_q, hw_wdg_d;
  logic [2:0] osc_sel_q, osc_sel_d;
  obd_osc_t osc_kind_q, osc_kind_d;
  obd_lvd_t lvd_q, lvd_d;

  // Run-time outputs
  logic irq0_q, irq0_d, irq1_q, irq1_d, halt_rst_q, halt_rst_d;

  obd_nvstore #(
    .PMEM_DEPTH(PMEM_DEPTH),
    .FACTORY(FACTORY),
    .ROM_OPT0(ROM_OPT0),
    .ROM_OPT1(ROM_OPT1)
  ) u_store (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .nv_blank(nv_blank),
    .wr_opt0(wr_opt0),
    .wr_opt1(wr_opt1),
    .wr_pmem(wr_pmem),
    .wr_index(pmem_idx(avs_address)),
    .wr_data(avs_writedata[7:0]),
    .erase_start(erase_start),
    .rd_index(pmem_idx(avs_address)),
    .opt0(opt0),
    .opt1(opt1),
    .pmem_rd(pmem_rd),
    .erase_busy(erase_busy)
  );

  obd_decode u_decode (
    .opt0(opt0),
    .opt1(opt1),
    .ext_irq_map_select(dec_map),
    .readout_protect(dec_prot),
    .clock_filter_off(dec_cfo),
    .clock_source_select(dec_osc_sel),
    .osc_kind(dec_osc_kind),
    .low_voltage_detect_select(dec_lvd),
    .watchdog_halt_reset(dec_whr),
    .watchdog_software_mode(dec_wsw)
  );

  // Bus slave: decode, write strobes, read data, erase wait
  always_comb begin
    st_d = st_q;
    rdata_d = rdata_q;
    wr_opt0 = 1'b0;
    wr_opt1 = 1'b0;
    wr_pmem = 1'b0;
    erase_start = 1'b0;
    case (st_q)
      BUS_IDLE: begin
        if (avs_write) begin
          st_d = BUS_RESP;
          // Writes outside programming mode are silently dropped
          if (prog_mode && avs_byteenable[0]) begin
            if (avs_address == OFS_OPT0) begin
              if (opt0[OPT0_PROT_BIT] && !avs_writedata[OPT0_PROT_BIT] && !FACTORY) begin
                erase_start = 1'b1;
                st_d = BUS_ERASE;
              end else begin
                wr_opt0 = 1'b1;
              end
            end else if (avs_address == OFS_OPT1) begin
              wr_opt1 = 1'b1;
            end else if (pmem_hit(avs_address)) begin
              wr_pmem = 1'b1;
            end
          end
        end else if (avs_read) begin
          st_d = BUS_RESP;
          rdata_d = '0;
          if (avs_address == OFS_STAT) begin
            rdata_d[STAT_PROG_BIT] = prog_mode;
            rdata_d[STAT_ROM_BIT] = FACTORY;
            rdata_d[STAT_BUSY_BIT] = erase_busy;
            rdata_d[STAT_PROT_BIT] = dec_prot;
          end else if (prog_mode) begin
            if (avs_address == OFS_OPT0) rdata_d[7:0] = opt0;
            else if (avs_address == OFS_OPT1) rdata_d[7:0] = opt1;
            else if (pmem_hit(avs_address) && !dec_prot) rdata_d[7:0] = pmem_rd;
          end
        end
      end
      BUS_ERASE: begin
        // Hold the master off until the whole array reads zero
        if (!erase_busy) st_d = BUS_RESP;
      end
      BUS_RESP: st_d = BUS_IDLE;
      default: st_d = BUS_IDLE;
    endcase
    if (sys_rst) begin
      st_d = BUS_IDLE;
      rdata_d = '0;
    end
    wait_d = (st_d != BUS_RESP);
  end

  // Bus slave registers
  always_ff @(posedge sys_clk) begin
    st_q <= st_d;
    wait_q <= wait_d;
    rdata_q <= rdata_d;
  end

  // Configuration follows the store only while reset is held
  always_comb begin
    map_d = map_q;
    prot_d = prot_q;
    cfo_d = cfo_q;
    osc_sel_d = osc_sel_q;
    osc_kind_d = osc_kind_q;
    lvd_d = lvd_q;
    lvd_en_d = lvd_en_q;
    whr_d = whr_q;
    wsw_d = wsw_q;
    hw_wdg_d = hw_wdg_q;
    if (sys_rst) begin
      map_d = dec_map;
      prot_d = dec_prot;
      cfo_d = dec_cfo;
      osc_sel_d = dec_osc_sel;
      osc_kind_d = dec_osc_kind;
      lvd_d = dec_lvd;
      lvd_en_d = (dec_lvd != LVD_OFF);
      whr_d = dec_whr;
      wsw_d = dec_wsw;
      hw_wdg_d = !dec_wsw;
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk) begin
    map_q <= map_d;
    prot_q <= prot_d;
    cfo_q <= cfo_d;
    osc_sel_q <= osc_sel_d;
    osc_kind_q <= osc_kind_d;
    lvd_q <= lvd_d;
    lvd_en_q <= lvd_en_d;
    whr_q <= whr_d;
    wsw_q <= wsw_d;
    hw_wdg_q <= hw_wdg_d;
  end

  // Interrupt vector requests and halt reset request
  always_comb begin
    irq0_d = (|port_a_irq) | (!map_q & (|port_c_irq));
    irq1_d = (|port_b_irq) | (map_q & (|port_c_irq));
    halt_rst_d = halt_entry & whr_q & (hw_wdg_q | watchdog_sw_enable);
    if (sys_rst) begin
      irq0_d = 1'b0;
      irq1_d = 1'b0;
      halt_rst_d = 1'b0;
    end
  end

  // Run-time output registers
  always_ff @(posedge sys_clk) begin
    irq0_q <= irq0_d;
    irq1_q <= irq1_d;
    halt_rst_q <= halt_rst_d;
  end

  // Outputs straight from flip-flops
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign ext_irq0_req = irq0_q;
  assign ext_irq1_req = irq1_q;
  assign halt_reset_req = halt_rst_q;
  assign ext_irq_map_select = map_q;
  assign readout_protect = prot_q;
  assign clock_filter_off = cfo_q;
  assign clock_source_select = osc_sel_q;
  assign osc_kind = osc_kind_q;
  assign low_voltage_detect_enable = lvd_en_q;
  assign low_voltage_detect_select = lvd_q;
  assign watchdog_halt_reset = whr_q;
  assign watchdog_software_mode = wsw_q;
  assign watchdog_hw_enable = hw_wdg_q;

endmodule : obd_top

/* obd_checker.sv */
/*
  Checker for the option byte decoder: bus answer timing, refusals,
  vector mapping, halt reset request and static configuration.
  Assumes it is bound to obd_top and sees only its ports.
*/
`timescale 1ns/100ps
module obd_checker (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic prog_mode,
  input wire logic [obd_pkg::OBD_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [obd_pkg::OBD_DW-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [7:0] port_a_irq,
  input wire logic [7:0] port_b_irq,
  input wire logic [5:0] port_c_irq,
  input wire logic ext_irq0_req,
  input wire logic ext_irq1_req,
  input wire logic halt_entry,
  input wire logic watchdog_sw_enable,
  input wire logic halt_reset_req,
  input wire logic ext_irq_map_select,
  input wire logic readout_protect,
  input wire logic clock_filter_off,
  input wire logic [2:0] clock_source_select,
  input wire obd_pkg::obd_osc_t osc_kind,
  input wire logic low_voltage_detect_enable,
  input wire obd_pkg::obd_lvd_t low_voltage_detect_select,
  input wire logic watchdog_halt_reset,
  input wire logic watchdog_software_mode,
  input wire logic watchdog_hw_enable
);
  import obd_pkg::*;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Read request taken, then a one-cycle answer
  sequence read_taken;
    $rose(avs_read) && !avs_write;
  endsequence
  sequence one_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  read_answer_a: assert property (read_taken |=> one_answer)
    else $error("read not answered in one cycle");
  noprog_read_a: assert property (
    read_taken and !prog_mode and avs_address == OFS_OPT0
    |=> avs_readdata == 32'h0) else $error("option byte seen outside prog mode");
  // Vectors follow the mapped lines one cycle late
  irq0_map_a: assert property (!$past(sys_rst) |-> ext_irq0_req ==
    $past(|port_a_irq || (!ext_irq_map_select && |port_c_irq))) else $error("vector 0 wrong");
  irq1_map_a: assert property (!$past(sys_rst) |-> ext_irq1_req ==
    $past(|port_b_irq || (ext_irq_map_select && |port_c_irq))) else $error("vector 1 wrong");
  halt_req_a: assert property (!$past(sys_rst) |-> halt_reset_req ==
    $past(halt_entry && watchdog_halt_reset && (watchdog_hw_enable || watchdog_sw_enable)))
    else $error("halt reset request wrong");
  cfg_hold_a: assert property (!$past(sys_rst) |-> $stable({ext_irq_map_select,
    readout_protect, clock_filter_off, clock_source_select, osc_kind,
    low_voltage_detect_enable, low_voltage_detect_select, watchdog_halt_reset,
    watchdog_software_mode, watchdog_hw_enable})) else $error("configuration moved after reset");
  lvd_enable_a: assert property (low_voltage_detect_enable ==
    (low_voltage_detect_select != LVD_OFF)) else $error("detector enable wrong");
  wdg_hw_a: assert property (watchdog_hw_enable != watchdog_software_mode)
    else $error("hardware watchdog enable wrong");
  osc_kind_a: assert property (osc_kind == ((clock_source_select == 3'h5) ?
    OSC_EXT_RC : obd_osc_t'(clock_source_select))) else $error("oscillator kind wrong");
endmodule : obd_checker

bind obd_top obd_checker i_obd_checker (.*);

/* obd_prog_tool.sv */
/*
  Programming tool model: Avalon-MM master and programming mode line.
  Assumes the slave answers with a one-cycle low waitrequest.
*/
`timescale 1ns/100ps
module obd_prog_tool (
  input wire logic sys_clk,
  input wire logic avs_waitrequest,
  input wire logic [obd_pkg::OBD_DW-1:0] avs_readdata,
  output logic prog_mode,
  output logic [obd_pkg::OBD_AW-1:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [obd_pkg::OBD_DW-1:0] avs_writedata,
  output logic [3:0] avs_byteenable
);
  import obd_pkg::*;

  // Idle master at time zero
  initial begin
    prog_mode = 1'b0;
    avs_address = 10'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
  end

  // Only the tool enters programming mode
  task set_mode(input logic m);
    prog_mode <= m;
    @(posedge sys_clk);
  endtask : set_mode

  // Byte lanes for the following transfers
  task set_lanes(input logic [3:0] be);
    avs_byteenable <= be;
    @(posedge sys_clk);
  endtask : set_lanes

  // One transfer, held until waitrequest is sampled low
  task xfer(input logic wr, input logic [OBD_AW-1:0] a, input logic [OBD_DW-1:0] d,
            output logic [OBD_DW-1:0] q);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= ~d; // Released data no longer shows the last value
    avs_address <= ~a;
    @(posedge sys_clk);
  endtask : xfer
endmodule : obd_prog_tool

/* tb_top.sv */
/*
  Self-checking bench for obd_top: blank part, option decode table,
  vector mapping, halt reset, protection and erase.
  Assumes obd_checker is bound and the tool model drives the bus.
*/
`timescale 1ns/100ps
module tb_top;
  import obd_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst, nv_blank, prog_mode, avs_read, avs_write, avs_waitrequest;
  logic halt_entry, watchdog_sw_enable, halt_reset_req, ext_irq0_req, ext_irq1_req;
  logic ext_irq_map_select, readout_protect, clock_filter_off, low_voltage_detect_enable;
  logic watchdog_halt_reset, watchdog_software_mode, watchdog_hw_enable;
  logic [OBD_AW-1:0] avs_address;
  logic [OBD_DW-1:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [7:0] port_a_irq, port_b_irq;
  logic [5:0] port_c_irq;
  logic [2:0] clock_source_select;
  obd_osc_t osc_kind;
  obd_lvd_t low_voltage_detect_select;
  int bad_count = 0;
  int total_checks = 0;
  wire [14:0] cfg = {ext_irq_map_select, readout_protect, clock_filter_off,
    clock_source_select, osc_kind, low_voltage_detect_enable, low_voltage_detect_select,
    watchdog_halt_reset, watchdog_software_mode, watchdog_hw_enable};

  // Clock and instances
  always #4 sys_clk = ~sys_clk;
  obd_top i_obd_top (.*);
  obd_prog_tool i_obd_prog_tool (.*);

  // Expected configuration from the two option bytes
  function automatic logic [14:0] exp_cfg(input logic [7:0] a, input logic [7:0] b);
    return {a[1], a[0], b[7], b[6:4], (b[6:4] == 3'h5) ? 3'h4 : b[6:4],
      b[3:2] != 2'h3, b[3:2], b[1], b[0], !b[0]};
  endfunction : exp_cfg

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task complete_run;
    if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  task do_reset(input logic blank);
    sys_rst <= 1'b1;
    nv_blank <= blank;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    nv_blank <= 1'b0;
    @(posedge sys_clk);
  endtask : do_reset

  task rd(input logic [OBD_AW-1:0] a, input logic [31:0] exp);
    logic [31:0] q;
    i_obd_prog_tool.xfer(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask : rd

  task wr(input logic [OBD_AW-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_obd_prog_tool.xfer(1'b1, a, d, q);
  endtask : wr

  // Blank part, then access with and without programming mode
  task t_blank;
    do_reset(1'b1);
    check(cfg, exp_cfg(8'hFF, 8'hFF));
    rd(OFS_OPT0, 32'h0);
    rd(OFS_STAT, 32'h8);
    i_obd_prog_tool.set_mode(1'b1);
    rd(OFS_STAT, 32'h9);
    rd(OFS_OPT0, 32'hFF);
    rd(OFS_OPT1, 32'hFF);
    rd(OFS_PMEM, 32'h0);
    rd(10'h00C, 32'h0);
  endtask : t_blank

  // Every oscillator and detector code, mapping, halt and watchdog modes
  task t_decode;
    logic [7:0] a, b, pa, pb;
    pa = 8'hFF;
    pb = 8'hFF;
    for (int i = 0; i < 8; i++) begin
      a = {6'h3F, i[2], 1'b1};
      b = {i[0], i[2:0], i[1:0], i[1], i[0]};
      wr(OFS_OPT0, {24'h0, a});
      wr(OFS_OPT1, {24'h0, b});
      check(cfg, exp_cfg(pa, pb));
      do_reset(1'b0);
      check(cfg, exp_cfg(a, b));
      port_a_irq <= {7'h0, i[1]};
      port_b_irq <= {i[0], 7'h0};
      port_c_irq <= 6'h20;
      watchdog_sw_enable <= i[2];
      halt_entry <= 1'b1;
      repeat (2) @(posedge sys_clk);
      check({ext_irq0_req, ext_irq1_req}, {!a[1] | i[1], a[1] | i[0]});
      check(halt_reset_req, b[1] & (!b[0] | i[2]));
      port_a_irq <= 8'h00;
      port_b_irq <= 8'h00;
      port_c_irq <= 6'h00;
      halt_entry <= 1'b0;
      @(posedge sys_clk);
      pa = a;
      pb = b;
    end
  endtask : t_decode

  // Clearing protection erases everything, then programming mode gating
  task t_erase;
    rd(OFS_PMEM + 10'h004, 32'h0);
    wr(OFS_OPT0, 32'hFE);
    rd(OFS_OPT0, 32'h0);
    rd(OFS_OPT1, 32'h0);
    rd(OFS_PMEM + 10'h03C, 32'h0);
    wr(OFS_PMEM + 10'h00C, 32'h5A);
    rd(OFS_PMEM + 10'h00C, 32'h5A);
    i_obd_prog_tool.set_mode(1'b0);
    wr(OFS_OPT1, 32'hFF);
    rd(OFS_PMEM + 10'h00C, 32'h0);
    i_obd_prog_tool.set_mode(1'b1);
    rd(OFS_OPT1, 32'h0);
    // A write without lane 0 must leave the option byte alone
    i_obd_prog_tool.set_lanes(4'hE);
    wr(OFS_OPT1, 32'hFF);
    i_obd_prog_tool.set_lanes(4'hF);
    rd(OFS_OPT1, 32'h0);
    do_reset(1'b0);
    check(cfg, exp_cfg(8'h00, 8'h00));
  endtask : t_erase

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    nv_blank = 1'b1;
    port_a_irq = 8'h00;
    port_b_irq = 8'h00;
    port_c_irq = 6'h00;
    halt_entry = 1'b0;
    watchdog_sw_enable = 1'b0;
    @(posedge sys_clk);
    t_blank;
    t_decode;
    t_erase;
    complete_run;
  end

  // Hang guard, well beyond the few hundred cycles the tests take
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    complete_run;
  end
endmodule : tb_top
